// [src/flsp_pkg.sv]
// Purpose : Shared constants and types for the suspend-parameter flash link.
// Assumes : One 40 MHz core clock drives both ends of the link.
// Notes   : The table bytes are built from their fields so that each field stays visible.

// ****************************************************************
// Package
// ****************************************************************
package flsp_pkg;

  // ****************************************************************
  // Table addresses and fixed bytes
  // ****************************************************************
  localparam logic [7:0] ADDR_TIMING_TOP = 8'h5B;
  localparam logic [7:0] ADDR_SUSP_B0    = 8'h5C;
  localparam logic [7:0] ADDR_SUSP_B1    = 8'h5D;
  localparam logic [7:0] ADDR_SUSP_B2    = 8'h5E;
  localparam logic [7:0] ADDR_SUSP_B3    = 8'h5F;

  // Top byte of the program and chip-erase timing word.
  localparam logic       CE_RESERVED     = 1'h1;
  localparam logic [1:0] CE_UNIT         = 2'h2;   // 4 s granularity.
  localparam logic [4:0] CE_COUNT        = 5'h01;  // Two units, 8 s typical.
  localparam logic [7:0] TIMING_TOP_BYTE = {CE_RESERVED, CE_UNIT, CE_COUNT};

  // Suspend-characteristics word, fields from bit 31 down to bit 0.
  localparam logic       SR_NOT_SUPP     = 1'h0;
  localparam logic [1:0] ES_LAT_UNIT     = 2'h1;   // 1 us granularity.
  localparam logic [4:0] ES_LAT_COUNT    = 5'h13;  // Twenty units.
  localparam logic [3:0] ES_GAP_COUNT    = 4'h1;   // Two 64 us units.
  localparam logic [1:0] PS_LAT_UNIT     = 2'h1;
  localparam logic [4:0] PS_LAT_COUNT    = 5'h13;
  localparam logic [3:0] PS_GAP_COUNT    = 4'h1;
  localparam logic       SW_RFU          = 1'h1;
  localparam logic [3:0] ES_PROHIBIT     = 4'hE;
  localparam logic [3:0] PS_PROHIBIT     = 4'hD;
  localparam logic [31:0] SUSP_WORD      = {SR_NOT_SUPP, ES_LAT_UNIT, ES_LAT_COUNT,
                                            ES_GAP_COUNT, PS_LAT_UNIT, PS_LAT_COUNT,
                                            PS_GAP_COUNT, SW_RFU, ES_PROHIBIT, PS_PROHIBIT};

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int ADDR_W     = 24;
  localparam int SECTOR_LSB = 12;
  localparam int PAGE_LSB   = 8;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ           = 40;
  localparam int SUSP_LAT_NS       = 20000;
  localparam int SUSP_LAT_MAX_CYC  = (SUSP_LAT_NS * CLK_MHZ) / 1000;          // Round down.
  localparam int RESUME_GAP_NS     = 128000;
  localparam int RESUME_GAP_CYC    = (RESUME_GAP_NS * CLK_MHZ + 999) / 1000;  // Round up.
  localparam int CNT_W             = 13;

  // ****************************************************************
  // Link commands
  // ****************************************************************
  typedef enum logic [2:0] {
    CMD_TBL_RD = 3'h0,
    CMD_TBL_WR = 3'h1,
    CMD_ARR_RD = 3'h2,
    CMD_ERASE  = 3'h3,
    CMD_PROG   = 3'h4,
    CMD_SUSP   = 3'h5,
    CMD_RESUME = 3'h6,
    CMD_NOP    = 3'h7
  } flsp_cmd_t;

  localparam logic [7:0] ARRAY_FILL = 8'hFF;

endpackage : flsp_pkg

// [src/flsp_if.sv]
// Purpose : Link between the flash host end and the flash device end.
// Assumes : Both ends run on the same core clock.
// Notes   : Requests are one-cycle pulses; every request gets one ack pulse.
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Interface
// ****************************************************************
interface flsp_if import flsp_pkg::*; ();
  logic                    cmd_valid;
  flsp_cmd_t               cmd;
  logic [ADDR_W-1:0]       addr;
  logic [7:0]              wdata;
  logic                    ack;
  logic [7:0]              rdata;
  logic                    busy;
  logic                    suspended;

  modport host   (output cmd_valid, cmd, addr, wdata,
                  input  ack, rdata, busy, suspended);
  modport device (input  cmd_valid, cmd, addr, wdata,
                  output ack, rdata, busy, suspended);
endinterface : flsp_if

`default_nettype wire

// [src/flsp_timer.sv]
// Purpose : Down counter that reports when a minimum interval has run out.
// Assumes : A start pulse reloads the full count at any time.
// Notes   : Reads as done after reset, so nothing waits without a cause.
`timescale 1ns/10ps
`default_nettype none

module flsp_timer
  import flsp_pkg::*;
#(
  parameter int W     = CNT_W,
  parameter int COUNT = RESUME_GAP_CYC
) (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // Control
  input  wire logic i_start,
  output logic      o_done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } flsp_tmr_t;

  flsp_tmr_t s;
  flsp_tmr_t next_s;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Reload on start, otherwise count down to zero and hold there.
  always_comb begin
    next_s = s;
    if (i_start) begin
      next_s.cnt = W'(COUNT);
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - W'(1);
    end
  end

  // Registered state.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_done = (s.cnt == '0);

endmodule : flsp_timer

`default_nettype wire

// [src/flsp_device.sv]
// Purpose : Device end: parameter table responder and suspendable erase/program engine.
// Assumes : The host keeps the resume-to-suspend gap and the suspend restrictions.
// Notes   : Only table bytes 5Bh to 5Fh are served here; others read as zero.
`timescale 1ns/10ps
`default_nettype none

module flsp_device
  import flsp_pkg::*;
#(
  parameter int ERASE_CYC = 4000,
  parameter int PROG_CYC  = 1000,
  parameter int HALT_CYC  = 16
) (
  // Clock and reset
  input  wire logic   i_core_clk,
  input  wire logic   i_rst,
  // Link to the host
  flsp_if.device      link,
  // User-side status
  output logic        o_busy,
  output logic        o_suspended,
  output logic        o_op_done
);

  // Halting never takes longer than the advertised worst case. The suspended state
  // shows one edge after the count runs out, so the clamp sits one below the bound.
  localparam int HALT_EFF = (HALT_CYC < SUSP_LAT_MAX_CYC) ? HALT_CYC : SUSP_LAT_MAX_CYC - 1;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ERASE = 6'h02,
    ST_PROG  = 6'h04,
    ST_HALT  = 6'h08,
    ST_SUSP  = 6'h10,
    ST_NEST  = 6'h20
  } flsp_dev_st_t;

  typedef struct packed {
    flsp_dev_st_t     st;
    logic             kind_erase;  // Kind of the operation that can be suspended.
    logic [CNT_W-1:0] run_cnt;     // Remaining work, frozen while suspended.
    logic [CNT_W-1:0] aux_cnt;     // Halt latency or nested operation count.
    logic             ack;
    logic [7:0]       rdata;
    logic             done;
  } flsp_dev_t;

  localparam flsp_dev_t DEV_RST = '{st: ST_IDLE, kind_erase: 1'h0, run_cnt: '0,
                                    aux_cnt: '0, ack: 1'h0, rdata: 8'h00, done: 1'h0};

  flsp_dev_t s;
  flsp_dev_t next_s;

  // ****************************************************************
  // Table lookup
  // ****************************************************************
  function automatic logic [7:0] flsp_tbl_byte(input logic [7:0] a);
    logic [7:0] b;
    b = 8'h00;
    unique case (a)
      ADDR_TIMING_TOP: b = TIMING_TOP_BYTE;
      ADDR_SUSP_B0:    b = SUSP_WORD[7:0];
      ADDR_SUSP_B1:    b = SUSP_WORD[15:8];
      ADDR_SUSP_B2:    b = SUSP_WORD[23:16];
      ADDR_SUSP_B3:    b = SUSP_WORD[31:24];
      default:         b = 8'h00;
    endcase
    return b;
  endfunction : flsp_tbl_byte

  logic go;
  assign go = link.cmd_valid;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Command answers first, then the operation engine.
  always_comb begin
    next_s      = s;
    next_s.ack  = 1'h0;
    next_s.done = 1'h0;
    if (go) begin
      next_s.ack = 1'h1;
      if (link.cmd == CMD_TBL_RD) begin
        next_s.rdata = flsp_tbl_byte(link.addr[7:0]);
      end else if (link.cmd == CMD_ARR_RD) begin
        next_s.rdata = ARRAY_FILL;
      end
    end
    unique case (s.st)
      ST_IDLE: begin
        if (go && link.cmd == CMD_ERASE) begin
          next_s.st         = ST_ERASE;
          next_s.kind_erase = 1'h1;
          next_s.run_cnt    = CNT_W'(ERASE_CYC);
        end else if (go && link.cmd == CMD_PROG) begin
          next_s.st         = ST_PROG;
          next_s.kind_erase = 1'h0;
          next_s.run_cnt    = CNT_W'(PROG_CYC);
        end
      end
      ST_ERASE, ST_PROG: begin
        if (go && link.cmd == CMD_SUSP) begin
          next_s.st      = ST_HALT;
          next_s.aux_cnt = CNT_W'(HALT_EFF);
        end else if (s.run_cnt <= CNT_W'(1)) begin
          next_s.st   = ST_IDLE;
          next_s.done = 1'h1;
        end else begin
          next_s.run_cnt = s.run_cnt - CNT_W'(1);
        end
      end
      ST_HALT: begin
        if (s.aux_cnt <= CNT_W'(1)) begin
          next_s.st = ST_SUSP;
        end else begin
          next_s.aux_cnt = s.aux_cnt - CNT_W'(1);
        end
      end
      ST_SUSP: begin
        // A nested operation of the other kind may run while suspended.
        if (go && link.cmd == CMD_RESUME) begin
          next_s.st = s.kind_erase ? ST_ERASE : ST_PROG;
        end else if (go && link.cmd == CMD_PROG && s.kind_erase) begin
          next_s.st      = ST_NEST;
          next_s.aux_cnt = CNT_W'(PROG_CYC);
        end else if (go && link.cmd == CMD_ERASE && !s.kind_erase) begin
          next_s.st      = ST_NEST;
          next_s.aux_cnt = CNT_W'(ERASE_CYC);
        end
      end
      ST_NEST: begin
        if (s.aux_cnt <= CNT_W'(1)) begin
          next_s.st   = ST_SUSP;
          next_s.done = 1'h1;
        end else begin
          next_s.aux_cnt = s.aux_cnt - CNT_W'(1);
        end
      end
      default: begin
        next_s = DEV_RST;
      end
    endcase
  end

  // Registered state.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= DEV_RST;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Status is decoded from the registered state only.
  assign link.ack       = s.ack;
  assign link.rdata     = s.rdata;
  assign link.busy      = (s.st == ST_ERASE) || (s.st == ST_PROG) ||
                          (s.st == ST_HALT) || (s.st == ST_NEST);
  assign link.suspended = (s.st == ST_SUSP) || (s.st == ST_NEST);
  assign o_busy         = link.busy;
  assign o_suspended    = link.suspended;
  assign o_op_done      = s.done;

endmodule : flsp_device

`default_nettype wire

// [src/flsp_host.sv]
// Purpose : Host end: forwards user commands and refuses those a suspend forbids.
// Assumes : The device answers every link request with one ack pulse.
// Notes   : One request is outstanding at a time; ready drops until its ack.
`timescale 1ns/10ps
`default_nettype none

module flsp_host
  import flsp_pkg::*;
#(
  parameter int GAP_CYC = RESUME_GAP_CYC
) (
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // Link to the device
  flsp_if.host                   link,
  // User command port
  input  wire logic              i_cmd_valid,
  input  wire flsp_cmd_t         i_cmd,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  output logic                   o_cmd_ready,
  // User answer port
  output logic                   o_done,
  output logic                   o_reject,
  output logic [7:0]             o_rdata
);

  typedef struct packed {
    logic              pend;       // Waiting for the device's ack.
    logic              lvalid;     // Link request pulse.
    flsp_cmd_t         lcmd;
    logic [ADDR_W-1:0] laddr;
    logic [7:0]        lwdata;
    logic              run_erase;  // Kind of the operation that may be suspended.
    logic [ADDR_W-1:0] run_addr;   // Its address, kept for the restrictions.
    logic              done;
    logic              reject;
    logic [7:0]        rdata;
  } flsp_host_t;

  localparam flsp_host_t HOST_RST = '{pend: 1'h0, lvalid: 1'h0, lcmd: CMD_NOP,
                                      laddr: '0, lwdata: 8'h00, run_erase: 1'h0,
                                      run_addr: '0, done: 1'h0, reject: 1'h0,
                                      rdata: 8'h00};

  flsp_host_t s;
  flsp_host_t next_s;

  logic gap_done;
  logic gap_start;
  logic ok;
  logic fire;
  logic susp_e;
  logic susp_p;
  logic sector_hit;
  logic page_hit;

  // ****************************************************************
  // Resume-to-suspend interval
  // ****************************************************************
  // One timer serves both kinds since both advertise the same interval.
  flsp_timer #(
    .W     (CNT_W),
    .COUNT (GAP_CYC)
  ) u_gap (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (gap_start),
    .o_done     (gap_done)
  );

  // ****************************************************************
  // Address matching
  // ****************************************************************
  function automatic logic flsp_same_unit(input logic [ADDR_W-1:0] a,
                                          input logic [ADDR_W-1:0] b,
                                          input int              lsb);
    logic [ADDR_W-1:0] m;
    m = '1;
    m = m << lsb;
    return ((a & m) == (b & m));
  endfunction : flsp_same_unit

  // The suspended kind follows the last operation started from idle.
  assign susp_e     = link.suspended && s.run_erase;
  assign susp_p     = link.suspended && !s.run_erase;
  assign sector_hit = flsp_same_unit(i_addr, s.run_addr, SECTOR_LSB);
  assign page_hit   = flsp_same_unit(i_addr, s.run_addr, PAGE_LSB);

  // ****************************************************************
  // Command admission
  // ****************************************************************
  // Nothing new starts while the device is busy, even a nested operation.
  always_comb begin
    ok = 1'h0;
    unique case (i_cmd)
      CMD_TBL_RD, CMD_TBL_WR: begin
        ok = 1'h1;
      end
      CMD_ARR_RD: begin
        ok = !(susp_p && page_hit);
      end
      CMD_ERASE: begin
        ok = !link.busy && !susp_e && !(susp_p && sector_hit);
      end
      CMD_PROG: begin
        ok = !link.busy && !susp_p && !(susp_e && sector_hit);
      end
      CMD_SUSP: begin
        ok = link.busy && !link.suspended && gap_done;
      end
      CMD_RESUME: begin
        ok = link.suspended && !link.busy;
      end
      default: begin
        ok = 1'h0;
      end
    endcase
  end

  assign o_cmd_ready = !s.pend;
  assign fire        = i_cmd_valid && !s.pend && ok;
  assign gap_start   = fire && (i_cmd == CMD_RESUME);

  // ****************************************************************
  // Next state
  // ****************************************************************
  // An ack and a new request cannot meet, since ready is low while pending.
  always_comb begin
    next_s        = s;
    next_s.lvalid = 1'h0;
    next_s.done   = 1'h0;
    next_s.reject = 1'h0;
    if (i_cmd_valid && !s.pend) begin
      if (ok) begin
        next_s.pend   = 1'h1;
        next_s.lvalid = 1'h1;
        next_s.lcmd   = i_cmd;
        next_s.laddr  = i_addr;
        next_s.lwdata = i_wdata;
        if ((i_cmd == CMD_ERASE || i_cmd == CMD_PROG) && !link.suspended) begin
          next_s.run_erase = (i_cmd == CMD_ERASE);
          next_s.run_addr  = i_addr;
        end
      end else begin
        next_s.reject = 1'h1;
      end
    end
    if (s.pend && link.ack) begin
      next_s.pend  = 1'h0;
      next_s.done  = 1'h1;
      next_s.rdata = link.rdata;
    end
  end

  // Registered state.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= HOST_RST;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.cmd_valid = s.lvalid;
  assign link.cmd       = s.lcmd;
  assign link.addr      = s.laddr;
  assign link.wdata     = s.lwdata;
  assign o_done         = s.done;
  assign o_reject       = s.reject;
  assign o_rdata        = s.rdata;

endmodule : flsp_host

`default_nettype wire

// [test/flsp_assertions.sv]
// Purpose : Concurrent checks on the link between the host end and the device end.
// Assumes : One core clock; reset is asynchronous and active high.
// Notes   : The suspended kind and address are tracked from the link itself.
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Checker
// ****************************************************************
module flsp_assertions
  import flsp_pkg::*;
#(
  parameter int GAP_CYC = RESUME_GAP_CYC
) (
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // Host to device
  input  wire logic              cmd_valid,
  input  wire flsp_cmd_t         cmd,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  // Device to host
  input  wire logic              ack,
  input  wire logic [7:0]        rdata,
  input  wire logic              busy,
  input  wire logic              suspended
);
  logic              sus_erase;
  logic [ADDR_W-1:0] sus_addr;
  int                gap_left;
  logic              fresh;

  // A new operation starts only from idle; nested ones leave the record alone.
  assign fresh = cmd_valid && !busy && !suspended && (cmd == CMD_ERASE || cmd == CMD_PROG);

  // Record what a suspend would halt; the gap counter keeps two cycles of slack.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sus_erase <= 1'b0;
      sus_addr  <= '0;
      gap_left  <= 0;
    end else begin
      if (fresh) begin
        sus_erase <= (cmd == CMD_ERASE);
        sus_addr  <= addr;
      end
      if (cmd_valid && cmd == CMD_RESUME) begin
        gap_left <= GAP_CYC - 2;
      end else if (gap_left > 0) begin
        gap_left <= gap_left - 1;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_ack_one_pulse: assert property ( // link handshake
    cmd_valid |=> ack ##1 !ack) else $error("ack is not a single pulse after a request");
  a_ack_has_cause: assert property ( // link handshake
    ack |-> $past(cmd_valid)) else $error("ack without a request");
  a_table_word: assert property (
    cmd_valid && cmd == CMD_TBL_RD && addr[7:2] == 6'h17
    |=> rdata == 8'(32'h331663ED >> {$past(addr[1:0]), 3'h0}))
    else $error("suspend word byte wrong");
  a_table_top: assert property (
    cmd_valid && cmd == CMD_TBL_RD && addr[7:0] == 8'h5B |=> rdata == 8'hC1)
    else $error("timing top byte wrong");
  a_halt_bound: assert property (
    cmd_valid && cmd == CMD_SUSP && busy && !suspended |-> ##[1:800] (suspended && !busy))
    else $error("operation not halted in time");
  a_no_nest_erase: assert property (
    cmd_valid && suspended && sus_erase |-> cmd != CMD_ERASE)
    else $error("erase sent during erase suspend");
  a_prog_sector: assert property (
    cmd_valid && suspended && sus_erase && cmd == CMD_PROG
    |-> addr[23:12] != sus_addr[23:12]) else $error("program in suspended sector");
  a_no_nest_prog: assert property (
    cmd_valid && suspended && !sus_erase |-> cmd != CMD_PROG)
    else $error("program sent during program suspend");
  a_read_page: assert property (
    cmd_valid && suspended && !sus_erase && cmd == CMD_ARR_RD
    |-> addr[23:8] != sus_addr[23:8]) else $error("read of suspended page");
  a_erase_page: assert property (
    cmd_valid && suspended && !sus_erase && cmd == CMD_ERASE
    |-> addr[23:12] != sus_addr[23:12]) else $error("erase over suspended page");
  a_resume_gap: assert property (
    cmd_valid && cmd == CMD_SUSP |-> gap_left == 0) else $error("suspend too soon after resume");

  c_suspend: cover property (cmd_valid && cmd == CMD_SUSP);
  c_resume: cover property (cmd_valid && cmd == CMD_RESUME);
  c_nested: cover property (cmd_valid && suspended && cmd == CMD_PROG);
endmodule : flsp_assertions

`default_nettype wire

// [test/flash_suspend_params_bench.sv]
// Purpose : Self-checking bench for the host and device ends joined by their link.
// Assumes : Inputs change at the falling edge; short counts shorten the run.
// Notes   : Expected bytes are written out here, not taken from the package.
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Bench
// ****************************************************************
module flash_suspend_params_bench import flsp_pkg::*;;
  localparam int GAP = 20;
  logic        core_clk;
  logic        rst;
  logic        v;
  flsp_cmd_t   cmd;
  logic [23:0] addr;
  logic [7:0]  wd;
  logic        rdy;
  logic        done;
  logic        rej_o;
  logic [7:0]  rdata;
  logic        dev_busy;
  logic        dev_susp;
  logic        op_done;
  int          op_count = 0;
  int          fail_count = 0;
  int          cmp_count = 0;

  flsp_if flsp_if_inst ();
  flsp_host #(.GAP_CYC(GAP)) flsp_host_inst (.i_core_clk(core_clk), .i_rst(rst),
    .link(flsp_if_inst), .i_cmd_valid(v), .i_cmd(cmd), .i_addr(addr), .i_wdata(wd),
    .o_cmd_ready(rdy), .o_done(done), .o_reject(rej_o), .o_rdata(rdata));
  flsp_device #(.ERASE_CYC(100), .PROG_CYC(80), .HALT_CYC(4)) flsp_device_inst (
    .i_core_clk(core_clk), .i_rst(rst), .link(flsp_if_inst), .o_busy(dev_busy),
    .o_suspended(dev_susp), .o_op_done(op_done));
  flsp_assertions #(.GAP_CYC(GAP)) flsp_assertions_inst (.i_core_clk(core_clk), .i_rst(rst),
    .cmd_valid(flsp_if_inst.cmd_valid), .cmd(flsp_if_inst.cmd), .addr(flsp_if_inst.addr),
    .wdata(flsp_if_inst.wdata), .ack(flsp_if_inst.ack), .rdata(flsp_if_inst.rdata),
    .busy(flsp_if_inst.busy), .suspended(flsp_if_inst.suspended));

  // Free-running 40 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Count completion pulses at the falling edge, where they have settled.
  always @(negedge core_clk) begin
    if (op_done === 1'b1) begin
      op_count++;
    end
  end

  // Compare one value and count it.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask : chk

  // One user command; the request is held across exactly one taking edge.
  task automatic req(input flsp_cmd_t c, input logic [23:0] a, input logic rej,
                     output logic [7:0] rd);
    int n;
    n = 0;
    @(negedge core_clk);
    while (rdy !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    v = 1'b1;
    cmd = c;
    addr = a;
    wd = ~a[7:0];
    @(negedge core_clk);
    v = 1'b0;
    n = 0;
    while (done !== 1'b1 && rej_o !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk("answer", 32'h1, 32'(n < 20));
    chk("refusal", {31'h0, rej}, {31'h0, rej_o});
    rd = rdata;
  endtask : req

  // Wait until the device rests, suspended or idle, and report the cycles taken.
  task automatic wait_rest(input logic want_susp, output int n);
    n = 0;
    while (!(dev_susp === want_susp && dev_busy === 1'b0) && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    chk("rest reached", 32'h1, 32'(n < 2000));
  endtask : wait_rest

  // Table bytes, their fields, an ignored write and a refused NOP command.
  task automatic t_table();
    logic [7:0] rd;
    logic [7:0] exp_b [5] = '{8'hC1, 8'hED, 8'h63, 8'h16, 8'h33};
    for (int i = 0; i < 5; i++) begin
      req(CMD_TBL_RD, 24'h00005B + 24'(i), 1'b0, rd);
      chk("table byte", {24'h0, exp_b[i]}, {24'h0, rd});
    end
    chk("suspend support bit", 32'h0, {31'h0, rd[7]});
    req(CMD_TBL_RD, 24'h00005B, 1'b0, rd);
    chk("erase unit", 32'h2, {30'h0, rd[6:5]});
    chk("erase count", 32'h1, {27'h0, rd[4:0]});
    req(CMD_TBL_WR, 24'h00005C, 1'b0, rd);
    req(CMD_TBL_RD, 24'h00005C, 1'b0, rd);
    chk("byte after write", 32'hED, {24'h0, rd});
    req(CMD_NOP, 24'h0, 1'b1, rd);
    $display("table test finished");
  endtask : t_table

  // Erase suspend: halt bound, forbidden starts, nested program, resume gap.
  task automatic t_erase();
    logic [7:0] rd;
    int         n;
    req(CMD_ERASE, 24'h012345, 1'b0, rd);
    req(CMD_SUSP, 24'h0, 1'b0, rd);
    wait_rest(1'b1, n);
    chk("erase halt cycles", 32'h1, 32'(n <= 800));
    req(CMD_ERASE, 24'h300000, 1'b1, rd);
    req(CMD_PROG, 24'h012F00, 1'b1, rd);
    req(CMD_PROG, 24'h034000, 1'b0, rd);
    wait_rest(1'b1, n);
    req(CMD_RESUME, 24'h0, 1'b0, rd);
    req(CMD_SUSP, 24'h0, 1'b1, rd);
    wait_rest(1'b0, n);
    chk("erase finished", 32'h1, 32'(n < 2000));
    @(negedge core_clk);
    chk("operations done", 32'h2, 32'(op_count));
    $display("erase suspend test finished");
  endtask : t_erase

  // Program suspend: halt bound, forbidden starts, reads, gap then a second suspend.
  task automatic t_prog();
    logic [7:0] rd;
    int         n;
    req(CMD_PROG, 24'h056789, 1'b0, rd);
    req(CMD_SUSP, 24'h0, 1'b0, rd);
    wait_rest(1'b1, n);
    chk("program halt cycles", 32'h1, 32'(n <= 800));
    req(CMD_PROG, 24'h200000, 1'b1, rd);
    req(CMD_ARR_RD, 24'h0567F0, 1'b1, rd);
    req(CMD_ARR_RD, 24'h056800, 1'b0, rd);
    chk("array read", 32'hFF, {24'h0, rd});
    req(CMD_ERASE, 24'h056000, 1'b1, rd);
    req(CMD_ERASE, 24'h100000, 1'b0, rd);
    wait_rest(1'b1, n);
    req(CMD_RESUME, 24'h0, 1'b0, rd);
    repeat (GAP + 2) @(negedge core_clk);
    req(CMD_SUSP, 24'h0, 1'b0, rd);
    wait_rest(1'b1, n);
    req(CMD_RESUME, 24'h0, 1'b0, rd);
    wait_rest(1'b0, n);
    chk("program finished", 32'h1, 32'(n < 2000));
    @(negedge core_clk);
    chk("operations done", 32'h4, 32'(op_count));
    $display("program suspend test finished");
  endtask : t_prog

  // Print the counts and the verdict, then stop.
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence after five cycles of reset.
  initial begin
    rst = 1'b1;
    v = 1'b0;
    cmd = CMD_NOP;
    addr = 24'h0;
    wd = 8'h00;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_table();
    t_erase();
    t_prog();
    end_of_test();
  end

  // Watchdog: the tests need well under a thousand cycles, so twenty thousand means a hang.
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    end_of_test();
  end
endmodule : flash_suspend_params_bench

`default_nettype wire
